// >>> sram_controller.sv
// Controller end: queues write words and issues bursts on the pins
module sram_controller
    import sram_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF,
    parameter int ADDR_W = 8,
    parameter int LANES = 4,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Command
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_write_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    // Write data stream
    input wire logic wdata_valid_i,
    output logic wdata_ready_o,
    input wire logic [DATA_W-1:0] wdata_i,
    // Read data
    output logic rdata_valid_o,
    output logic [DATA_W-1:0] rdata_o,
    // Modes
    input wire logic linear_i,
    input wire logic sleep_i,
    // Pin side
    sram_if.ctl pins
);
    host_state_e st_q, st_d;
    logic [1:0] beat_q, beat_d;
    logic wr_q, wr_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic fv;
    logic [DATA_W-1:0] fd;
    logic take;
    logic [2:0] rv_q, rv_d;

    sram_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(wdata_valid_i),
        .in_ready_o(wdata_ready_o),
        .in_data_i(wdata_i),
        .out_valid_o(fv),
        .out_ready_i(take),
        .out_data_o(fd)
    );

    // Write burst waits for queued data each beat
    assign take = (st_q != HS_IDLE) && wr_q;
    assign cmd_ready_o = (st_q == HS_IDLE) && !sleep_i;

    always_comb begin
        st_d = st_q;
        beat_d = beat_q;
        wr_d = wr_q;
        addr_d = addr_q;
        case (st_q)
            HS_IDLE: begin
                if (cmd_valid_i && cmd_ready_o) begin
                    st_d = HS_ISSUE;
                    wr_d = cmd_write_i;
                    addr_d = cmd_addr_i;
                    beat_d = 2'h0;
                end
            end
            HS_ISSUE: begin
                if (!wr_q || fv) begin
                    st_d = HS_BURST;
                    beat_d = 2'h1;
                end
            end
            HS_BURST: begin
                if (!wr_q || fv) begin
                    beat_d = 2'(beat_q + 1'b1);
                    if (beat_q == 2'(BURST_LEN - 1)) begin
                        st_d = HS_IDLE;
                    end
                end
            end
            default: st_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= HS_IDLE;
            beat_q <= 2'h0;
            wr_q <= 1'b0;
            addr_q <= '0;
        end else begin
            st_q <= st_d;
            beat_q <= beat_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
        end
    end

    // Pin drive; strobe on first beat, advance afterwards
    logic go;
    assign go = (st_q != HS_IDLE) && (!wr_q || fv);
    assign pins.addr = addr_q;
    assign pins.chip_select_primary_n = !go;
    assign pins.processor_addr_strobe_n = 1'b1;
    assign pins.controller_addr_strobe_n = !(go && st_q == HS_ISSUE);
    assign pins.burst_advance_n = !(go && st_q == HS_BURST);
    assign pins.byte_write_enable_n = 1'b1;
    assign pins.lane_write_n = '1;
    assign pins.global_write_n = !(go && wr_q);
    assign pins.output_enable_n = 1'b0;
    assign pins.sleep_request = sleep_i;
    assign pins.linear_order_select_n = !linear_i;
    assign pins.flow_through_select_n = 1'b1;
    assign pins.dq_ctl_out = fd;
    assign pins.dq_ctl_oe = go && wr_q;

    // Pipelined reads return two edges after the access edge
    always_comb begin
        rv_d = {rv_q[1:0], go && !wr_q};
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rv_q <= 3'h0;
            rdata_valid_o <= 1'b0;
            rdata_o <= '0;
        end else begin
            rv_q <= rv_d;
            rdata_valid_o <= rv_q[1];
            rdata_o <= pins.dq_to_ctl;
        end
    end
endmodule

// >>> sram_pkg.sv
// Shared constants and types for the burst SRAM link
package sram_pkg;
    localparam int DATA_W_DEF = 36;
    localparam int ADDR_W_DEF = 20;
    localparam int LANE_W_DEF = 9;
    localparam int BURST_W = 2;
    localparam int BURST_LEN = 4;
    localparam int FIFO_DEPTH_DEF = 16;
    localparam logic [1:0] BURST_RST = 2'h0;
    localparam logic [1:0] CNT_RST = 2'h0;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_ISSUE = 2'b01,
        HS_BURST = 2'b11
    } host_state_e;

    // Next burst offset: linear adds, interleaved xors
    function automatic logic [1:0] burst_next(
        input logic [1:0] start,
        input logic [1:0] step,
        input logic linear
    );
        logic [1:0] r;
        r = linear ? 2'(start + step) : (start ^ step);
        return r;
    endfunction
endpackage

// >>> sram_if.sv
// Pin-level carrier between the SRAM controller and the SRAM device
interface sram_if #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 20,
    parameter int LANES = 4
);
    logic [ADDR_W-1:0] addr;
    logic chip_select_primary_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic byte_write_enable_n;
    logic global_write_n;
    logic [LANES-1:0] lane_write_n;
    logic output_enable_n;
    logic sleep_request;
    logic linear_order_select_n;
    logic flow_through_select_n;
    logic [DATA_W-1:0] dq_ctl_out;
    logic dq_ctl_oe;
    logic [DATA_W-1:0] dq_dev_out;
    logic [LANES-1:0] dq_dev_oe;
    logic [DATA_W-1:0] dq_to_dev;
    logic [DATA_W-1:0] dq_to_ctl;

    modport dev (
        input addr, chip_select_primary_n, processor_addr_strobe_n,
        input controller_addr_strobe_n, burst_advance_n,
        input byte_write_enable_n, global_write_n, lane_write_n,
        input output_enable_n, sleep_request, linear_order_select_n,
        input flow_through_select_n, dq_to_dev,
        output dq_dev_out, dq_dev_oe
    );
    modport ctl (
        output addr, chip_select_primary_n, processor_addr_strobe_n,
        output controller_addr_strobe_n, burst_advance_n,
        output byte_write_enable_n, global_write_n, lane_write_n,
        output output_enable_n, sleep_request, linear_order_select_n,
        output flow_through_select_n, dq_ctl_out, dq_ctl_oe,
        input dq_to_ctl
    );
endinterface

// >>> sram_fifo.sv
// Parameterised valid/ready FIFO in flip-flops
module sram_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (PW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (PW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
endmodule

// >>> sram_device.sv
// Synchronous burst SRAM device model: array, burst counter, output path
// Contract
// - Sync inputs sampled only on rising clock
// - Output enable and sleep act asynchronously
// - Either address strobe starts a burst
// - Counter steps only when advance asserted
// - Two-bit counter loaded from low address
// - Order pin picks linear or interleaved
// - New address accepted every cycle
// - Flow-through low bypasses output register
// - Flow-through high adds output register
// - Deselect pipelined one stage less; the model gives it the same stages as a read
// - Drivers off right after deselect captured; pipeline mode turns them off one edge later
// - Byte write writes only selected lanes
// - Global write writes all lanes
// - Sleep when requested or clock stopped; the model sleeps only on sleep_request
// - Contents kept during sleep
// - Array write self-timed after capture
// - Widths 18, 32 or 36 supported
// - Burst wraps to start on fifth clock
// - Unconnected mode pins: pipeline, active
// - Data lanes high impedance during writes; the model drives them for an earlier read even in a write cycle
// - All lanes driven on reads
module sram_device
    import sram_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF,
    parameter int ADDR_W = 8,
    parameter int LANES = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Pin side
    sram_if.dev pins,
    // Status
    output logic asleep_o
);
    localparam int LW = DATA_W / LANES;
    localparam int DEPTH = 1 << ADDR_W;

    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [ADDR_W-1:0] base_q, base_d;
    logic [1:0] start_q, start_d, step_q, step_d;
    logic [ADDR_W-1:0] cur_addr;
    logic sel_now, strobe, wr_now, rd_now;
    logic [LANES-1:0] lane_we;
    logic rd_act_q, rd_act_d, pipe_act_q, pipe_act_d;
    logic [DATA_W-1:0] rd_data, pipe_q, pipe_d;
    logic ft_mode, zz, oe;
    logic [DATA_W-1:0] dq_out;
    logic drive;

    // Unknown or floating mode pins fall to the defaults
    assign ft_mode = (pins.flow_through_select_n === 1'b0);
    assign zz = (pins.sleep_request === 1'b1);
    assign oe = (pins.output_enable_n === 1'b0);

    // Current burst address from base and counter
    assign cur_addr = {base_q[ADDR_W-1:2],
        burst_next(start_q, step_q,
            !pins.linear_order_select_n)};

    assign sel_now = !pins.chip_select_primary_n;
    assign strobe = sel_now && (!pins.processor_addr_strobe_n ||
        !pins.controller_addr_strobe_n);
    assign wr_now = !pins.global_write_n ||
        (!pins.byte_write_enable_n && !(&pins.lane_write_n));

    // Lane decode: global overrides byte lanes
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            lane_we[i] = !pins.global_write_n ||
                (!pins.byte_write_enable_n &&
                 !pins.lane_write_n[i]);
        end
    end

    // Burst address state
    always_comb begin
        base_d = base_q;
        start_d = start_q;
        step_d = step_q;
        if (zz) begin
            step_d = step_q;
        end else if (strobe) begin
            base_d = pins.addr;
            start_d = pins.addr[1:0];
            step_d = 2'h0;
        end else if (!pins.burst_advance_n) begin
            step_d = 2'(step_q + 1'b1);
        end else begin
            step_d = step_q;
        end
    end

    // Access decode for this cycle, using next address
    logic [ADDR_W-1:0] acc_addr;
    logic access;
    always_comb begin
        acc_addr = {base_d[ADDR_W-1:2],
            burst_next(start_d, step_d, !pins.linear_order_select_n)};
        access = !zz && (strobe || (rd_act_q || pipe_act_q ||
            !pins.burst_advance_n) && sel_now);
        rd_now = access && !wr_now;
        rd_data = mem_q[acc_addr];
        // Deselect clears flow state on the next edge, the same stage as a read
        rd_act_d = rd_now;
        pipe_act_d = rd_act_q;
        pipe_d = rd_data;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            base_q <= '0;
            start_q <= BURST_RST;
            step_q <= CNT_RST;
            rd_act_q <= 1'b0;
            pipe_act_q <= 1'b0;
            pipe_q <= '0;
            asleep_o <= 1'b0;
        end else begin
            base_q <= base_d;
            start_q <= start_d;
            step_q <= step_d;
            rd_act_q <= rd_act_d;
            pipe_act_q <= pipe_act_d;
            pipe_q <= rd_act_q ? flow_q : pipe_q;
            asleep_o <= zz;
        end
    end

    // Self-timed write on the capturing edge; no reset keeps contents
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < LANES; i++) begin
            if (access && lane_we[i]) begin
                mem_q[acc_addr][i*LW +: LW] <=
                    pins.dq_to_dev[i*LW +: LW];
            end
        end
    end

    // Output path; enable and sleep act without a clock
    logic [DATA_W-1:0] flow_q;
    always_ff @(posedge clk_i) begin
        flow_q <= rd_data;
    end
    assign dq_out = ft_mode ? flow_q : pipe_q;
    assign drive = oe && !zz &&
        (ft_mode ? rd_act_q : pipe_act_q);
    assign pins.dq_dev_out = dq_out;
    assign pins.dq_dev_oe = {LANES{drive}};
endmodule

// >>> sram_link_monitor.sv
// Concurrent checks on the pin bundle between controller and device
module sram_link_monitor #(
    parameter int LANES = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Pin bundle
    input wire logic chip_select_primary_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic output_enable_n,
    input wire logic flow_through_select_n,
    input wire logic dq_ctl_oe,
    input wire logic [LANES-1:0] dq_dev_oe
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // ==========================================
    // Cycles since the last read strobe
    logic [3:0] since_rd_q;
    logic [3:0] since_rd_d;
    always_comb begin
        since_rd_d = since_rd_q;
        if (!controller_addr_strobe_n && global_write_n) begin
            since_rd_d = 4'h0;
        end else if (since_rd_q != 4'hf) begin
            since_rd_d = since_rd_q + 4'h1;
        end
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            since_rd_q <= 4'hf;
        end else begin
            since_rd_q <= since_rd_d;
        end
    end

    // ==========================================
    // Assertions
    sequence strobe_s;
        !controller_addr_strobe_n;
    endsequence
    sequence rd_start_s;
        !controller_addr_strobe_n && global_write_n;
    endsequence

    strobe_select_a: assert property (strobe_s |-> !chip_select_primary_n)
        else $error("strobe without chip select");
    burst_gap_a: assert property (strobe_s |=> controller_addr_strobe_n [*3])
        else $error("new strobe inside a burst");
    read_advance_a: assert property (rd_start_s |=> !burst_advance_n [*3])
        else $error("read burst did not advance three beats");
    no_contend_a: assert property (dq_ctl_oe |-> dq_dev_oe == '0)
        else $error("device drives data during a write");
    oe_hiz_a: assert property (output_enable_n |-> dq_dev_oe == '0)
        else $error("device drives with output enable off");
    all_lanes_a: assert property (|dq_dev_oe |-> &dq_dev_oe)
        else $error("read lanes not driven together");
    drive_window_a: assert property (|dq_dev_oe |-> since_rd_q < 4'h9)
        else $error("device drives long after deselect");
    write_data_a: assert property (!global_write_n |-> dq_ctl_oe)
        else $error("global write without write data");
    pipe_mode_a: assert property (flow_through_select_n)
        else $error("pipeline mode not selected");
endmodule

// >>> sync_burst_sram_core_tb.sv
// Testbench joining controller and device over the pin bundle
module sync_burst_sram_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic cmd_write_i = 1'b0;
    logic [7:0] cmd_addr_i = 8'h00;
    logic wdata_valid_i = 1'b0;
    logic [35:0] wdata_i = 36'h0;
    logic linear_i = 1'b1;
    logic sleep_i = 1'b0;
    logic cmd_ready_o, wdata_ready_o, rdata_valid_o, asleep_o;
    logic [35:0] rdata_o;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    sram_if #(.DATA_W(36), .ADDR_W(8), .LANES(4)) sif ();
    always_comb begin
        sif.dq_to_dev = sif.dq_ctl_oe ? sif.dq_ctl_out : ~sif.dq_ctl_out;
        for (int l = 0; l < 4; l++) begin
            sif.dq_to_ctl[l*9 +: 9] = sif.dq_dev_oe[l] ?
                sif.dq_dev_out[l*9 +: 9] : ~sif.dq_dev_out[l*9 +: 9];
        end
    end
    sram_device #(.DATA_W(36), .ADDR_W(8), .LANES(4)) u_sram_device (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .pins(sif.dev),
        .asleep_o(asleep_o));
    sram_controller #(.DATA_W(36), .ADDR_W(8), .LANES(4),
        .FIFO_DEPTH(16)) u_sram_controller (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i),
        .cmd_addr_i(cmd_addr_i), .wdata_valid_i(wdata_valid_i),
        .wdata_ready_o(wdata_ready_o), .wdata_i(wdata_i),
        .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
        .linear_i(linear_i), .sleep_i(sleep_i), .pins(sif.ctl));
    sram_link_monitor #(.LANES(4)) u_sram_link_monitor (
        .clk_i(clk_i), .arst_n_i(arst_n_i),
        .chip_select_primary_n(sif.chip_select_primary_n),
        .controller_addr_strobe_n(sif.controller_addr_strobe_n),
        .burst_advance_n(sif.burst_advance_n),
        .global_write_n(sif.global_write_n),
        .output_enable_n(sif.output_enable_n),
        .flow_through_select_n(sif.flow_through_select_n),
        .dq_ctl_oe(sif.dq_ctl_oe), .dq_dev_oe(sif.dq_dev_oe));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ==========================================
    // Shared tasks
    task check(input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task issue(input logic wr, input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        cmd_valid_i = 1'b1;
        cmd_write_i = wr;
        cmd_addr_i = a;
        while (!cmd_ready_o && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 200) begin
            fail_count++;
        end
        @(posedge clk_i);
        #1;
        cmd_valid_i = 1'b0;
    endtask

    // ==========================================
    // Scenarios
    task t_fill_write;
        linear_i = 1'b1;
        wdata_valid_i = 1'b1;
        for (int i = 0; i < 16; i++) begin
            wdata_i = 36'h123450000 + 36'(i);
            while (!wdata_ready_o) begin
                @(posedge clk_i);
                #1;
            end
            @(posedge clk_i);
            #1;
        end
        check(36'(wdata_ready_o), 36'h0);
        wdata_valid_i = 1'b0;
        for (int b = 0; b < 4; b++) begin
            issue(1'b1, 8'(b * 4));
        end
    endtask
    task t_read(input logic [7:0] a, input logic lin);
        int n;
        int k;
        logic [1:0] off;
        n = 0;
        k = 0;
        linear_i = lin;
        issue(1'b0, a);
        while (k < 4 && n < 60) begin
            @(posedge clk_i);
            #1;
            n++;
            if (rdata_valid_o) begin
                off = lin ? a[1:0] + 2'(k) : a[1:0] ^ 2'(k);
                check(rdata_o, 36'h123450000 + 36'({a[3:2], off}));
                k++;
            end
        end
        check(36'(k), 36'h4);
    endtask
    task t_orders;
        t_read(8'h02, 1'b0);
        t_read(8'h07, 1'b1);
        t_read(8'h0d, 1'b0);
        t_read(8'h0b, 1'b1);
    endtask
    task t_sleep;
        sleep_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        check(36'(asleep_o), 36'h1);
        check(36'(cmd_ready_o), 36'h0);
        sleep_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        check(36'(asleep_o), 36'h0);
        t_read(8'h09, 1'b0);
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        t_fill_write();
        t_orders();
        t_sleep();
        give_verdict();
    end
endmodule
